/* core/pts_core.sv */
// module: configuration word store, tuning bit and clock source selector decode
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
module pts_core
    import pts_pkg::*;
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // set select pin
    input  wire logic             set_select_pin,
    // clock source selectors
    output logic      [1:0]       out_a_source,
    output logic      [1:0]       out_b_source,
    output logic      [1:0]       out_c_source,
    output logic      [1:0]       out_d_source,
    // pll tuning controls
    output logic                  loop_filter_slow_pll_a,
    output logic                  loop_filter_slow_pll_b,
    output logic                  loop_filter_slow_pll_c,
    output logic                  pump_current_high_pll_a,
    output logic                  pump_current_high_pll_b,
    output logic                  pump_current_high_pll_c
);

    // picks the first or second stored set by the pin level
    function automatic logic [1:0] pick2(input logic second, input logic [1:0] a, input logic [1:0] b);
        pick2 = second ? b : a;
    endfunction : pick2

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    logic              rst_s1;
    logic              rst_n;
    logic              pin_s1;
    logic              pin_s;
    logic [CFG_W-1:0]  cfg;
    logic [CFG_W-1:0]  next_cfg;
    logic              next_ack;
    logic [31:0]       next_dat;
    logic [31:0]       status;
    logic              req;
    logic [1:0]        next_src_a;
    logic [1:0]        next_src_b;
    logic [1:0]        next_src_c;
    logic [1:0]        next_src_d;
    logic              next_lf_a;
    logic              next_lf_b;
    logic              next_lf_c;
    logic              next_pump_a;
    logic              next_pump_b;
    logic              next_pump_c;

    // reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // pin synchroniser, only pin_s is read by logic
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 1'b0;
            pin_s  <= 1'b0;
        end else begin
            pin_s1 <= set_select_pin;
            pin_s  <= pin_s1;
        end
    end

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // status view of the block's live outputs
    always_comb begin
        status                      = 32'h0;
        status[ST_SRC_A +: 2]       = out_a_source;
        status[ST_SRC_B +: 2]       = out_b_source;
        status[ST_SRC_C +: 2]       = out_c_source;
        status[ST_SRC_D +: 2]       = out_d_source;
        status[ST_LF_A]             = loop_filter_slow_pll_a;
        status[ST_LF_B]             = loop_filter_slow_pll_b;
        status[ST_LF_C]             = loop_filter_slow_pll_c;
        status[ST_PUMP_A]           = pump_current_high_pll_a;
        status[ST_PUMP_B]           = pump_current_high_pll_b;
        status[ST_PUMP_C]           = pump_current_high_pll_c;
        status[ST_SET]              = pin_s;
    end

    // bus next values: one-wait ack, byte-lane writes, zero for unmapped reads
    always_comb begin
        next_cfg = cfg;
        next_ack = req;
        next_dat = wb_dat_o;
        if (req) begin
            next_dat = 32'h0;
            unique case (wb_adr_i)
                ADR_CFG0: begin
                    next_dat = cfg[31:0];
                    if (wb_we_i) next_cfg[31:0] = merge(cfg[31:0], wb_dat_i, wb_sel_i);
                end
                ADR_CFG1: begin
                    next_dat = cfg[63:32];
                    if (wb_we_i) next_cfg[63:32] = merge(cfg[63:32], wb_dat_i, wb_sel_i);
                end
                ADR_CFG2: begin
                    next_dat = cfg[95:64];
                    if (wb_we_i) next_cfg[95:64] = merge(cfg[95:64], wb_dat_i, wb_sel_i);
                end
                ADR_CFG3: begin
                    next_dat = cfg[127:96];
                    if (wb_we_i) next_cfg[127:96] = merge(cfg[127:96], wb_dat_i, wb_sel_i);
                end
                ADR_STATUS: next_dat = status;
                default:    next_dat = 32'h0;
            endcase
        end
    end

    // bus registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg      <= CFG_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            cfg      <= next_cfg;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // decode of selectors and tuning bits from the stored word
    always_comb begin
        next_src_a = cfg[SRC_A_LO +: 2];                                        // see R10
        next_src_b = cfg[SRC_B_LO +: 2];                                        // see R10
        // selector changes pass straight through; a running output may glitch
        next_src_c = pick2(pin_s, cfg[SRC_C1_LO +: 2], cfg[SRC_C2_LO +: 2]);   // see R1 see R2 see R9
        next_src_d = pick2(pin_s, cfg[SRC_D1_LO +: 2], cfg[SRC_D2_LO +: 2]);   // see R1 see R2 see R9
        next_lf_a  = cfg[LF_A_BIT];                                             // see R3 see R10
        next_lf_b  = cfg[LF_B_BIT];                                             // see R3
        next_lf_c  = pin_s ? cfg[LF_C2_BIT] : cfg[LF_C1_BIT];                   // see R4
        next_pump_a = cfg[PUMP_A_BIT];                                          // see R5 see R10
        next_pump_b = cfg[PUMP_B_BIT];                                          // see R5
        next_pump_c = pin_s ? cfg[PUMP_C2_BIT] : cfg[PUMP_C1_BIT];              // see R6
    end

    // output registers; tuning levels change in one clean step so the loop slews
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_a_source            <= SRC_REF;
            out_b_source            <= SRC_REF;
            out_c_source            <= SRC_REF;
            out_d_source            <= SRC_REF;
            loop_filter_slow_pll_a  <= 1'b0;
            loop_filter_slow_pll_b  <= 1'b0;
            loop_filter_slow_pll_c  <= 1'b0;
            pump_current_high_pll_a <= 1'b0;
            pump_current_high_pll_b <= 1'b0;
            pump_current_high_pll_c <= 1'b0;
        end else begin
            out_a_source            <= next_src_a;
            out_b_source            <= next_src_b;
            out_c_source            <= next_src_c;
            out_d_source            <= next_src_d;
            loop_filter_slow_pll_a  <= next_lf_a;                               // see R8
            loop_filter_slow_pll_b  <= next_lf_b;                               // see R8
            loop_filter_slow_pll_c  <= next_lf_c;                               // see R8
            pump_current_high_pll_a <= next_pump_a;                             // see R8
            pump_current_high_pll_b <= next_pump_b;                             // see R8
            pump_current_high_pll_c <= next_pump_c;                             // see R8
        end
    end

    // checks on the bus, pin synchroniser and decode, all in the sys_clk domain
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // a bus request answered after one wait, then ack drops
    sequence bus_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence bus_ack_s;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_ack_a: assert property (bus_req_s |-> bus_ack_s)
        else $error("bus ack not one pulse after request");

    // pin low path for output c and d
    c_first_set_a: assert property (!pin_s ##1 1'b1 |->                         // see R1
        out_c_source == $past(cfg[SRC_C1_LO +: 2]) && out_d_source == $past(cfg[SRC_D1_LO +: 2]))
        else $error("first set selector not applied");

    // pin high path for output c and d
    c_second_set_a: assert property (pin_s ##1 1'b1 |->                         // see R2
        out_c_source == $past(cfg[SRC_C2_LO +: 2]) && out_d_source == $past(cfg[SRC_D2_LO +: 2]))
        else $error("second set selector not applied");

    // pll a and b loop filter bits
    lf_ab_bits_a: assert property (##1 loop_filter_slow_pll_a == $past(cfg[LF_A_BIT])   // see R3
        && loop_filter_slow_pll_b == $past(cfg[LF_B_BIT]))
        else $error("pll a or b loop filter bit wrong");

    // pll c loop filter follows pin
    lf_c_select_a: assert property (##1 loop_filter_slow_pll_c ==               // see R4
        ($past(pin_s) ? $past(cfg[LF_C2_BIT]) : $past(cfg[LF_C1_BIT])))
        else $error("pll c loop filter bit wrong");

    // pll a and b charge pump bits
    cp_ab_bits_a: assert property (##1 pump_current_high_pll_a == $past(cfg[PUMP_A_BIT])  // see R5
        && pump_current_high_pll_b == $past(cfg[PUMP_B_BIT]))
        else $error("pll a or b pump bit wrong");

    // pll c charge pump follows pin
    cp_c_select_a: assert property (##1 pump_current_high_pll_c ==              // see R6
        ($past(pin_s) ? $past(cfg[PUMP_C2_BIT]) : $past(cfg[PUMP_C1_BIT])))
        else $error("pll c pump bit wrong");

    // pll a loop filter moves only after its stored bit moved
    tune_step_a: assert property ($changed(loop_filter_slow_pll_a) |->          // see R8
        $past(cfg[LF_A_BIT], 2) != $past(cfg[LF_A_BIT]))
        else $error("tuning output changed without cause");

    // output c selector changes only after a config or pin change
    c_src_cause_a: assert property ($changed(out_c_source) |->                  // see R9
        $past(cfg, 2) != $past(cfg) || $past(pin_s, 2) != $past(pin_s))
        else $error("output c selector changed without cause");

    // a and b selectors ignore the pin
    ab_src_fixed_a: assert property ($changed(pin_s) && $stable(cfg) |=>        // see R10
        $stable(out_a_source) && $stable(out_b_source))
        else $error("output a or b selector moved with pin");

    // pin reaches the synchronised copy within three cycles
    sequence pin_hold_s;
        set_select_pin ##1 set_select_pin ##1 set_select_pin ##1 set_select_pin;
    endsequence
    pin_sync_a: assert property (pin_hold_s |-> pin_s)                          // see R2
        else $error("pin not synchronised in time");

    // output d selector changes only after a config or pin change
    d_src_cause_a: assert property ($changed(out_d_source) |->                  // see R9
        $past(cfg, 2) != $past(cfg) || $past(pin_s, 2) != $past(pin_s))
        else $error("output d selector changed without cause");

    // pll b loop filter moves only after its stored bit moved
    tune_b_step_a: assert property ($changed(loop_filter_slow_pll_b) |->        // see R8
        $past(cfg[LF_B_BIT], 2) != $past(cfg[LF_B_BIT]))
        else $error("pll b loop filter changed without cause");

    // pll a pump current moves only after its stored bit moved
    pump_a_step_a: assert property ($changed(pump_current_high_pll_a) |->       // see R8
        $past(cfg[PUMP_A_BIT], 2) != $past(cfg[PUMP_A_BIT]))
        else $error("pll a pump current changed without cause");

    // pll b pump current moves only after its stored bit moved
    pump_b_step_a: assert property ($changed(pump_current_high_pll_b) |->       // see R8
        $past(cfg[PUMP_B_BIT], 2) != $past(cfg[PUMP_B_BIT]))
        else $error("pll b pump current changed without cause");

    // pll a and b tuning ignores the pin
    ab_tune_fixed_a: assert property ($changed(pin_s) && $stable(cfg) |=>       // see R10
        $stable(loop_filter_slow_pll_a) && $stable(loop_filter_slow_pll_b)
        && $stable(pump_current_high_pll_a) && $stable(pump_current_high_pll_b))
        else $error("pll a or b tuning moved with pin");

    // a low pin reaches the synchronised copy within three cycles
    sequence pin_low_s;
        !set_select_pin ##1 !set_select_pin ##1 !set_select_pin ##1 !set_select_pin;
    endsequence
    pin_low_sync_a: assert property (pin_low_s |-> !pin_s)                      // see R1
        else $error("low pin not synchronised in time");

    // a read of the first config word returns the stored bits with the ack
    sequence cfg0_read_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == ADR_CFG0;
    endsequence
    cfg_read_a: assert property (cfg0_read_s |=> wb_ack_o && wb_dat_o == $past(cfg[31:0]))
        else $error("config word read data wrong");

    // writes to the status address leave the stored word alone
    sequence status_write_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == ADR_STATUS;
    endsequence
    status_write_a: assert property (status_write_s |=> $stable(cfg))
        else $error("status write changed the stored word");

    // ack rises only after a strobed cycle
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");

endmodule : pts_core

/* core/pts_pkg.sv */
// package: configuration word layout and register map for pll tuning and source select
//
// Summary of operation
// R1 - selector code 0 ref, 1-3 plls a-c; pin low: c, d use 71:70, 95:94
// R2 - pin high: outputs c and d use selectors at bits 125:124 and 127:126
// R3 - loop filter bit: 0 short 7us, 1 long 20us; pll a bit 20, b 44
// R4 - pll c loop filter bit from 68 when pin low, 92 when pin high
// R5 - charge pump bit: 0 low 2uA, 1 high 10uA; pll a bit 19, b 43
// R6 - pll c charge pump bit from 67 when pin low, 91 when pin high
// R7 - host clocks serial configuration at 10 to 100 kbit/s; this design takes Wishbone word writes instead
// R8 - pll tuning changes in operation move frequency smoothly, without glitches
// R9 - selector or post divider changes while running may glitch that output
// R10 - output a/b selectors and pll a/b tuning apply whatever the pin level
package pts_pkg;
    // configuration word
    localparam int          CFG_W       = 128;
    localparam logic [127:0] CFG_RESET  = 128'h0;
    // tuning bit positions
    localparam int PUMP_A_BIT  = 19;
    localparam int LF_A_BIT    = 20;
    localparam int PUMP_B_BIT  = 43;
    localparam int LF_B_BIT    = 44;
    localparam int PUMP_C1_BIT = 67;
    localparam int LF_C1_BIT   = 68;
    localparam int PUMP_C2_BIT = 91;
    localparam int LF_C2_BIT  = 92;
    // selector field low bits, each field two bits wide
    localparam int SRC_A_LO   = 22;
    localparam int SRC_B_LO   = 46;
    localparam int SRC_C1_LO  = 70;
    localparam int SRC_D1_LO  = 94;
    localparam int SRC_C2_LO  = 124;
    localparam int SRC_D2_LO  = 126;
    // source codes
    localparam logic [1:0] SRC_REF    = 2'h0;
    localparam logic [1:0] SRC_PLL_A  = 2'h1;
    localparam logic [1:0] SRC_PLL_B  = 2'h2;
    localparam logic [1:0] SRC_PLL_C  = 2'h3;
    // analog meaning of the tuning bits, informational
    localparam int LF_SHORT_NS = 7000;
    localparam int LF_LONG_NS  = 20000;
    localparam int CP_LOW_NA   = 2000;
    localparam int CP_HIGH_NA  = 10000;
    // register map, byte addresses
    localparam int          ADR_W      = 8;
    localparam logic [7:0]  ADR_CFG0   = 8'h00;
    localparam logic [7:0]  ADR_CFG1   = 8'h04;
    localparam logic [7:0]  ADR_CFG2   = 8'h08;
    localparam logic [7:0]  ADR_CFG3   = 8'h0c;
    localparam logic [7:0]  ADR_STATUS = 8'h10;
    // status field positions
    localparam int ST_SRC_A = 0;
    localparam int ST_SRC_B = 2;
    localparam int ST_SRC_C = 4;
    localparam int ST_SRC_D = 6;
    localparam int ST_LF_A  = 8;
    localparam int ST_LF_B  = 9;
    localparam int ST_LF_C  = 10;
    localparam int ST_PUMP_A = 11;
    localparam int ST_PUMP_B = 12;
    localparam int ST_PUMP_C = 13;
    localparam int ST_SET   = 14;
endpackage : pts_pkg

/* tb/pll_tuning_and_clock_source_select_test.sv */
// testbench: configuration decode, set select pin and register bus checks
module pll_tuning_and_clock_source_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pts_pkg::*;

    logic             sys_clk, rst_b, set_select_pin, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [ADR_W-1:0] wb_adr;
    logic [3:0]       wb_sel;
    logic [31:0]      wb_wdat, wb_rdat;
    logic [1:0]       src_a, src_b, src_c, src_d;
    wire logic [2:0]  lf, cp;
    logic [127:0]     cfg;
    int               num_errors = 0;
    int               n_tests = 0;

    // 100 MHz clock
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    pts_host host (.sys_clk(sys_clk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
        .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack));

    pts_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .set_select_pin(set_select_pin), .out_a_source(src_a), .out_b_source(src_b),
        .out_c_source(src_c), .out_d_source(src_d), .loop_filter_slow_pll_a(lf[0]),
        .loop_filter_slow_pll_b(lf[1]), .loop_filter_slow_pll_c(lf[2]), .pump_current_high_pll_a(cp[0]),
        .pump_current_high_pll_b(cp[1]), .pump_current_high_pll_c(cp[2]));

    // the single compare
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one bus cycle that must be acknowledged
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] dat, output logic [31:0] rd);
        logic ok;
        host.cycle(we, adr, sel, dat, rd, ok);
        chk("bus ack", 32'h1, {31'h0, ok});
    endtask : bus

    // write the whole configuration word
    task automatic put_cfg(input logic [127:0] c);
        logic [31:0] rd;
        for (int i = 0; i < 4; i++)
            bus(1'b1, 8'(4 * i), 4'hf, c[32 * i +: 32], rd);
        cfg = c;
    endtask : put_cfg

    // expected outputs and status from the stored word and pin level
    task automatic chk_state();
        logic [14:0] e;
        logic [31:0] rd;
        logic        p;
        // let a pin change settle through the synchroniser and output flops first
        repeat (4) @(posedge sys_clk);
        p = set_select_pin;
        e = {p, p ? cfg[PUMP_C2_BIT] : cfg[PUMP_C1_BIT], cfg[PUMP_B_BIT], cfg[PUMP_A_BIT],
             p ? cfg[LF_C2_BIT] : cfg[LF_C1_BIT], cfg[LF_B_BIT], cfg[LF_A_BIT],
             p ? cfg[SRC_D2_LO +: 2] : cfg[SRC_D1_LO +: 2], p ? cfg[SRC_C2_LO +: 2] : cfg[SRC_C1_LO +: 2],
             cfg[SRC_B_LO +: 2], cfg[SRC_A_LO +: 2]};
        chk("outputs", {18'h0, e[13:0]}, {18'h0, cp, lf, src_d, src_c, src_b, src_a});
        bus(1'b0, ADR_STATUS, 4'hf, 32'h0, rd);
        chk("status", {17'h0, e}, rd);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'(4 * i), 4'hf, 32'h0, rd);
            chk("cfg word", cfg[32 * i +: 32], rd);
        end
    endtask : chk_state

    // hold reset 20 cycles, then check cleared state
    task automatic t_reset();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk("reset outputs", 32'h0, {18'h0, cp, lf, src_d, src_c, src_b, src_a});
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cfg = '0;
        chk_state();
        $display("test reset done");
    endtask : t_reset

    // every code in every selector, both pin levels, distinct sets
    task automatic t_codes();
        logic [127:0] c;
        logic [1:0]   k;
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            c = '0;
            {c[SRC_A_LO +: 2], c[SRC_B_LO +: 2], c[SRC_C1_LO +: 2]} = {k, ~k, k};
            {c[SRC_D1_LO +: 2], c[SRC_C2_LO +: 2], c[SRC_D2_LO +: 2]} = {k + 2'h1, ~k, k + 2'h2};
            {c[LF_A_BIT], c[LF_B_BIT], c[LF_C1_BIT], c[LF_C2_BIT]} = {k[0], k[1], k[0], ~k[0]};
            {c[PUMP_A_BIT], c[PUMP_B_BIT], c[PUMP_C1_BIT], c[PUMP_C2_BIT]} = {~k[0], ^k, k[1], ~k[1]};
            put_cfg(c);
            set_select_pin <= 1'b0;
            chk_state();
            set_select_pin <= 1'b1;
            chk_state();
        end
        $display("test codes done");
    endtask : t_codes

    // single byte lane, unmapped and status writes ignored
    task automatic t_lanes();
        logic [31:0] rd;
        bus(1'b1, ADR_CFG0, 4'h4, 32'hffffffff, rd);
        cfg[23:16] = 8'hff;
        bus(1'b1, 8'h14, 4'hf, 32'hffffffff, rd);
        bus(1'b1, ADR_STATUS, 4'hf, 32'h0, rd);
        bus(1'b0, 8'h14, 4'hf, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        chk_state();
        $display("test lanes done");
    endtask : t_lanes

    // verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // main sequence, second reset taken with the pin high
    initial begin
        rst_b = 1'b0;
        set_select_pin = 1'b0;
        t_reset();
        t_codes();
        t_lanes();
        set_select_pin <= 1'b1;
        t_reset();
        end_sim();
    end

    // watchdog: run needs well under 2000 cycles, cut at 20000
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
endmodule : pll_tuning_and_clock_source_select_test

/* tb/pts_host.sv */
// module: wishbone master standing in for the configuration host
module pts_host
    import pts_pkg::*;
(
    // clock
    input  wire logic             sys_clk,
    // wishbone master side
    output logic                  wb_cyc_o,
    output logic                  wb_stb_o,
    output logic                  wb_we_o,
    output logic      [ADR_W-1:0] wb_adr_o,
    output logic      [3:0]       wb_sel_o,
    output logic      [31:0]      wb_dat_o,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic             wb_ack_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
    end

    // one classic cycle; word writes replace the slow serial transfer
    task automatic cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat, output logic [31:0] rdat, output logic ok);
        int waits;
        waits = 0;
        @(posedge sys_clk);
        {wb_cyc_o, wb_stb_o} <= 2'h3;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= dat;
        // wait for ack however long it takes; only the bench watchdog ends a hang
        @(posedge sys_clk);
        while (wb_ack_i !== 1'b1) begin
            waits++;
            @(posedge sys_clk);
        end
        // the slave answers after exactly one wait cycle
        ok = (waits == 1);
        rdat = wb_dat_i;
        // released lines no longer show the old request
        {wb_cyc_o, wb_stb_o} <= 2'h0;
        wb_we_o <= ~we;
        wb_adr_o <= ~adr;
        wb_dat_o <= ~dat;
    endtask : cycle
endmodule : pts_host
